// ---- core/ring_copy_dma.sv ----
`timescale 1ns/1ps
`include "copy_dma_map.svh"
module ring_copy_dma #(
   parameter int CNT_W = 16
) (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        sfr_wr_i,
   input  wire logic        sfr_rd_i,
   input  wire logic [7:0]  sfr_addr_i,
   input  wire logic [7:0]  sfr_wdata_i,
   output logic      [7:0]  sfr_rdata_o,
   input  wire logic [15:0] rx_packet_ring_i,
   input  wire logic [7:0]  rx_ring_first_page_i,
   input  wire logic [7:0]  rx_ring_last_page_i,
   input  wire logic [15:0] tx_packet_ring_i,
   input  wire logic [7:0]  tx_ring_first_page_i,
   input  wire logic [7:0]  tx_ring_last_page_i,
   input  wire logic [7:0]  chunk_gap_setting_i,
   input  wire logic        timer_hit_i,
   output logic             mem_req_o,
   output logic             mem_we_o,
   output logic      [23:0] mem_addr_o,
   output logic      [7:0]  mem_wdata_o,
   input  wire logic [7:0]  mem_rdata_i,
   input  wire logic        mem_ack_i,
   output logic             irq_o,
   output logic      [9:0]  timer_timeout_o,
   output logic             timer_run_o
);
   logic [7:0]       cmd, next_cmd;
   logic [23:0]      src, next_src;
   logic [23:0]      tgt, next_tgt;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic [15:0]      tmr, next_tmr;
   logic [7:0]       status, next_status;
   logic [7:0]       index, next_index;
   logic [23:0]      wbuf, next_wbuf;
   logic             wpend, next_wpend;
   logic [1:0]       rptr, next_rptr;
   logic [23:0]      cur_src, next_cur_src;
   logic [23:0]      cur_tgt, next_cur_tgt;
   logic [CNT_W-1:0] remain, next_remain;
   logic [7:0]       chunk_left, next_chunk_left;
   logic [7:0]       gap_cnt, next_gap_cnt;
   logic [7:0]       byte_hold, next_byte_hold;
   logic [7:0]       rdata, next_rdata;
   logic             irq, next_irq;
   copy_dma_pkg::engine_state_t state, next_state;
   logic [23:0]      src_step, tgt_step, sel_reg;
   logic             bad;
   logic [24:0]      src_end, tgt_end;
   logic [23:0]      rx_lo, rx_hi, tx_lo, tx_hi;
   function automatic logic [23:0] reg_value(input logic [7:0] idx, input logic [7:0] c,
                                             input logic [23:0] s, input logic [23:0] t,
                                             input logic [CNT_W-1:0] n, input logic [15:0] m);
      logic [23:0] v;
      unique case (idx)
         `IDX_CMD: v = {16'h0000, c};
         `IDX_SRC: v = s;
         `IDX_TGT: v = t;
         `IDX_CNT: v = {{(24-CNT_W){1'b0}}, n};
         `IDX_TMR: v = {8'h00, m};
         default:  v = 24'h000000;
      endcase
      return v;
   endfunction
   ring_addr_step u_src_step (
      .addr_i       (cur_src),
      .ring_i       (cmd[`CMD_SRC_RING]),
      .ring_base_i  (rx_packet_ring_i),
      .first_page_i (rx_ring_first_page_i),
      .last_page_i  (rx_ring_last_page_i),
      .next_addr_o  (src_step)
   );
   ring_addr_step u_tgt_step (
      .addr_i       (cur_tgt),
      .ring_i       (cmd[`CMD_TGT_RING]),
      .ring_base_i  (tx_packet_ring_i),
      .first_page_i (tx_ring_first_page_i),
      .last_page_i  (tx_ring_last_page_i),
      .next_addr_o  (tgt_step)
   );
   always_comb begin
      sel_reg = reg_value(index, cmd, src, tgt, cnt, tmr);
      src_end = {1'b0, src} + {{(25-CNT_W){1'b0}}, cnt};
      tgt_end = {1'b0, tgt} + {{(25-CNT_W){1'b0}}, cnt};
      rx_lo   = {rx_packet_ring_i, 8'h00} + {8'h00, rx_ring_first_page_i, 8'h00};
      rx_hi   = {rx_packet_ring_i, 8'hFF} + {8'h00, rx_ring_last_page_i, 8'h00};
      tx_lo   = {tx_packet_ring_i, 8'h00} + {8'h00, tx_ring_first_page_i, 8'h00};
      tx_hi   = {tx_packet_ring_i, 8'hFF} + {8'h00, tx_ring_last_page_i, 8'h00};
      bad = (cnt == '0) || (src == tgt)
         || (({1'b0, tgt} < src_end) && ({1'b0, src} < tgt_end))
         || (cmd[`CMD_SRC_RING] && ((src < rx_lo) || (src > rx_hi)))
         || (cmd[`CMD_TGT_RING] && ((tgt < tx_lo) || (tgt > tx_hi)));
   end
   always_comb begin
      next_cmd        = cmd;
      next_src        = src;
      next_tgt        = tgt;
      next_cnt        = cnt;
      next_tmr        = tmr;
      next_status     = status;
      next_index      = index;
      next_wbuf       = wbuf;
      next_wpend      = wpend;
      next_rptr       = rptr;
      next_cur_src    = cur_src;
      next_cur_tgt    = cur_tgt;
      next_remain     = remain;
      next_chunk_left = chunk_left;
      next_gap_cnt    = gap_cnt;
      next_byte_hold  = byte_hold;
      next_rdata      = rdata;
      next_irq        = 1'b0;
      next_state      = state;
      if (sfr_rd_i && sfr_addr_i == `SFR_DATA) begin
         next_rdata = sel_reg[rptr*8 +: 8];
         next_rptr  = (rptr == 2'd2) ? 2'd0 : rptr + 2'd1;
      end else if (sfr_rd_i && sfr_addr_i == `SFR_STATUS) begin
         next_rdata = status;
      end
      // data bytes shift in lsb first
      if (sfr_wr_i && sfr_addr_i == `SFR_DATA) begin
         next_wbuf  = {sfr_wdata_i, wbuf[23:8]};
         next_wpend = 1'b1;
      end
      if (sfr_wr_i && sfr_addr_i == `SFR_INDEX) begin
         next_index = sfr_wdata_i;
         next_rptr  = 2'd0;
         next_wpend = 1'b0;
         // commit only freshly loaded bytes, a read's index write must not
         if (wpend || sfr_wdata_i == `IDX_ABORT) begin
            unique case (sfr_wdata_i)
               `IDX_CMD: begin
                  next_cmd[`CMD_GO] = cmd[`CMD_GO] | wbuf[16 + `CMD_GO];
                  next_cmd[`CMD_FS]     = cmd[`CMD_FS] | wbuf[16 + `CMD_FS];
                  next_cmd[`CMD_IRQ_EN] = wbuf[16 + `CMD_IRQ_EN];
                  if (wbuf[16 + `CMD_GO] && !cmd[`CMD_GO]) begin
                     next_cmd[`CMD_SRC_RING] = wbuf[16 + `CMD_SRC_RING];
                     next_cmd[`CMD_TGT_RING] = wbuf[16 + `CMD_TGT_RING];
                  end
               end
               `IDX_SRC: next_src = wbuf;
               `IDX_TGT: next_tgt = wbuf;
               `IDX_CNT: next_cnt = wbuf[23:24-CNT_W];
               `IDX_TMR: next_tmr = wbuf[23:8];
               `IDX_ABORT: next_cmd[`CMD_FS] = cmd[`CMD_GO];
               default: ;
            endcase
         end
         if (sfr_wdata_i == `IDX_CMD) begin
            next_status[`STS_DONE] = 1'b0;
         end
      end
      // timer expiry sets the flag, only reset clears it
      if (timer_hit_i) begin
         next_status[`STS_TIMER] = 1'b1;
      end
      unique case (state)
         copy_dma_pkg::ST_IDLE: begin
            if (cmd[`CMD_GO] && !cmd[`CMD_FS] && !cmd[`CMD_ERR]) begin
               next_state = copy_dma_pkg::ST_CHECK;
            end
         end
         copy_dma_pkg::ST_CHECK: begin
            next_cur_src    = src;
            next_cur_tgt    = tgt;
            next_remain     = cnt;
            next_chunk_left = `CHUNK_BYTES;
            if (bad) begin
               next_cmd[`CMD_ERR] = 1'b1;
               next_state = copy_dma_pkg::ST_ERROR;
            end else begin
               next_state = copy_dma_pkg::ST_READ;
            end
         end
         copy_dma_pkg::ST_READ: begin
            if (mem_ack_i) begin
               next_byte_hold = mem_rdata_i;
               next_state = copy_dma_pkg::ST_WRITE;
            end
         end
         copy_dma_pkg::ST_WRITE: begin
            if (mem_ack_i) begin
               next_cur_src    = src_step;
               next_cur_tgt    = tgt_step;
               next_remain     = remain - 1'b1;
               next_chunk_left = chunk_left - 8'h01;
               if (remain == {{(CNT_W-1){1'b0}}, 1'b1}) begin
                  next_status[`STS_DONE] = 1'b1;
                  next_cmd[`CMD_GO]       = 1'b0;
                  next_cmd[`CMD_SRC_RING] = 1'b0;
                  next_cmd[`CMD_TGT_RING] = 1'b0;
                  next_irq   = cmd[`CMD_IRQ_EN];
                  next_state = copy_dma_pkg::ST_IDLE;
               end else if (chunk_left == 8'h01) begin
                  next_chunk_left = `CHUNK_BYTES;
                  next_gap_cnt    = chunk_gap_setting_i;
                  next_state      = copy_dma_pkg::ST_GAP;
               end else begin
                  next_state = copy_dma_pkg::ST_READ;
               end
            end
         end
         copy_dma_pkg::ST_GAP: begin
            if (gap_cnt == 8'h00) begin
               next_state = copy_dma_pkg::ST_READ;
            end else begin
               next_gap_cnt = gap_cnt - 8'h01;
            end
         end
         copy_dma_pkg::ST_ERROR: begin
            next_state = copy_dma_pkg::ST_ERROR;
         end
      endcase
      if (cmd[`CMD_FS] && state != copy_dma_pkg::ST_WRITE) begin
         next_cmd[`CMD_GO]       = 1'b0;
         next_cmd[`CMD_FS]       = 1'b0;
         next_cmd[`CMD_ERR]      = 1'b0;
         next_cmd[`CMD_SRC_RING] = 1'b0;
         next_cmd[`CMD_TGT_RING] = 1'b0;
         next_state = copy_dma_pkg::ST_IDLE;
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cmd        <= `CMD_RESET;
         src        <= 24'h000000;
         tgt        <= 24'h000000;
         cnt        <= '0;
         tmr        <= `TMR_RESET;
         status     <= 8'h00;
         index      <= 8'h00;
         wbuf       <= 24'h000000;
         wpend      <= 1'b0;
         rptr       <= 2'd0;
         cur_src    <= 24'h000000;
         cur_tgt    <= 24'h000000;
         remain     <= '0;
         chunk_left <= 8'h00;
         gap_cnt    <= 8'h00;
         byte_hold  <= 8'h00;
         rdata      <= 8'h00;
         irq        <= 1'b0;
         state      <= copy_dma_pkg::ST_IDLE;
      end else begin
         cmd        <= next_cmd;
         src        <= next_src;
         tgt        <= next_tgt;
         cnt        <= next_cnt;
         tmr        <= next_tmr;
         status     <= next_status;
         index      <= next_index;
         wbuf       <= next_wbuf;
         wpend      <= next_wpend;
         rptr       <= next_rptr;
         cur_src    <= next_cur_src;
         cur_tgt    <= next_cur_tgt;
         remain     <= next_remain;
         chunk_left <= next_chunk_left;
         gap_cnt    <= next_gap_cnt;
         byte_hold  <= next_byte_hold;
         rdata      <= next_rdata;
         irq        <= next_irq;
         state      <= next_state;
      end
   end
   assign sfr_rdata_o     = rdata;
   assign mem_req_o       = (state == copy_dma_pkg::ST_READ) || (state == copy_dma_pkg::ST_WRITE);
   assign mem_we_o        = (state == copy_dma_pkg::ST_WRITE);
   assign mem_addr_o      = (state == copy_dma_pkg::ST_WRITE) ? cur_tgt : cur_src;
   assign mem_wdata_o     = byte_hold;
   assign irq_o           = irq;
   assign timer_timeout_o = tmr[9:0];
   assign timer_run_o     = tmr[12];
   sequence s_last_write;
      state == copy_dma_pkg::ST_WRITE && mem_ack_i && remain == 1;
   endsequence
   a_done_after_last: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_last_write |=> status[`STS_DONE] && !cmd[`CMD_GO])
      else $error("done flag not set after last byte");
   a_launch_starts: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state == copy_dma_pkg::ST_IDLE && cmd[`CMD_GO] && !cmd[`CMD_FS] && !cmd[`CMD_ERR]
      |=> state == copy_dma_pkg::ST_CHECK)
      else $error("launch did not start copy");
   a_error_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state == copy_dma_pkg::ST_CHECK && bad && !cmd[`CMD_FS] |=> cmd[`CMD_ERR])
      else $error("error flag missing");
   a_chunk_limit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      mem_req_o |-> chunk_left != 8'h00 && chunk_left <= `CHUNK_BYTES)
      else $error("chunk exceeds limit");
   a_gap_entry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state == copy_dma_pkg::ST_WRITE && mem_ack_i && chunk_left == 1 && remain > 1
      && !cmd[`CMD_FS] |=> state == copy_dma_pkg::ST_GAP && gap_cnt == $past(chunk_gap_setting_i))
      else $error("gap not entered");
   a_linear_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state == copy_dma_pkg::ST_WRITE && mem_ack_i && !cmd[`CMD_SRC_RING] && !cmd[`CMD_TGT_RING]
      |=> cur_src == $past(cur_src) + 24'h000001 && cur_tgt == $past(cur_tgt) + 24'h000001)
      else $error("address did not step by one");
   a_go_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      cmd[`CMD_GO] && state == copy_dma_pkg::ST_READ && !cmd[`CMD_FS] |=> cmd[`CMD_GO])
      else $error("launch bit dropped mid copy");
   a_force_stop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      cmd[`CMD_FS] && state != copy_dma_pkg::ST_WRITE
      |=> state == copy_dma_pkg::ST_IDLE && !cmd[`CMD_FS] && !cmd[`CMD_GO])
      else $error("force stop not honoured");
   a_irq_enable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      irq_o |-> $past(cmd[`CMD_IRQ_EN]) && status[`STS_DONE])
      else $error("interrupt without enable");
   a_timer_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      timer_hit_i |=> status[`STS_TIMER])
      else $error("timer flag missing");
endmodule

// ---- core/copy_dma_map.svh ----
// Overview of operation
// - split copies into chunks of 128 bytes
// - idle gap between chunks, programmable length
// - linear address increment without ring modes
// - source wraps inside receive ring pages
// - target wraps inside transmit ring pages
// - ring flags held during copy, cleared after
// - launch bit starts copy, self-clears
// - writing zero to launch does nothing
// - force stop aborts, reads one until stopped
// - error flag on bad count or ranges
// - copy done flag in status bit 0
// - timer expired flag in status bit 1
// - index write selects register; 0xFF aborts
// - data reads return bytes LSB first
// - data writes buffered, committed on index write
// - internal map: 0x00,0x02,0x06,0x0A,0x0C
// - done interrupt when enable bit set
`ifndef COPY_DMA_MAP_SVH
`define COPY_DMA_MAP_SVH
`define SFR_STATUS       8'h94
`define SFR_INDEX        8'h9B
`define SFR_DATA         8'h9C
`define IDX_CMD          8'h00
`define IDX_SRC          8'h02
`define IDX_TGT          8'h06
`define IDX_CNT          8'h0A
`define IDX_TMR          8'h0C
`define IDX_ABORT        8'hFF
`define CMD_GO           0
`define CMD_FS           1
`define CMD_ERR          2
`define CMD_SRC_RING     4
`define CMD_TGT_RING     5
`define CMD_IRQ_EN       7
`define STS_DONE         0
`define STS_TIMER        1
`define CHUNK_BYTES      8'h80
`define CMD_RESET        8'h00
`define TMR_RESET        16'h0001
`endif

// ---- core/copy_dma_pkg.sv ----
package copy_dma_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CHECK,
      ST_READ,
      ST_WRITE,
      ST_GAP,
      ST_ERROR
   } engine_state_t;
endpackage

// ---- core/ring_addr_step.sv ----
`timescale 1ns/1ps
// next address: linear or wrapped within a page ring
module ring_addr_step (
   input  wire logic [23:0] addr_i,
   input  wire logic        ring_i,
   input  wire logic [15:0] ring_base_i,
   input  wire logic [7:0]  first_page_i,
   input  wire logic [7:0]  last_page_i,
   output logic      [23:0] next_addr_o
);
   logic [23:0] inc;
   logic [23:0] last_end;
   logic [23:0] first_start;
   always_comb begin
      inc         = addr_i + 24'h000001;
      last_end    = {ring_base_i, 8'hFF} + {8'h00, last_page_i, 8'h00};
      first_start = {ring_base_i, 8'h00} + {8'h00, first_page_i, 8'h00};
      next_addr_o = inc;
      if (ring_i && (addr_i == last_end)) begin
         next_addr_o = first_start;
      end
   end
endmodule

// ---- sim/mem_model.sv ----
`timescale 1ns/1ps
// byte memory on the copy engine's data bus; ack after 1 or 4 cycles
module mem_model (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        slow_i,
   input  wire logic        req_i,
   input  wire logic        we_i,
   input  wire logic [23:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   output logic      [7:0]  rdata_o,
   output logic             ack_o
);
   // only the low 64K of the address space is modelled
   logic [7:0] mem [0:65535];
   bit         vld [0:65535];
   logic [1:0] wait_cnt;
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_o <= 1'b0;
         wait_cnt <= 2'h0;
         rdata_o <= 8'h00;
      end else if (ack_o) begin
         // read data is gone once the ack cycle is over
         ack_o <= 1'b0;
         rdata_o <= ~rdata_o;
      end else if (req_i && (!slow_i || wait_cnt == 2'h3)) begin
         ack_o <= 1'b1;
         wait_cnt <= 2'h0;
         if (we_i) begin
            mem[addr_i[15:0]] = wdata_i;
            vld[addr_i[15:0]] = 1'b1;
         end else begin
            rdata_o <= vld[addr_i[15:0]] ? mem[addr_i[15:0]] : addr_i[7:0] ^ 8'h5A;
         end
      end else if (req_i) begin
         wait_cnt <= wait_cnt + 2'h1;
      end else begin
         rdata_o <= ~rdata_o;
      end
   end
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
   $display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end
module testbench;
   logic        clk = 1'b0;
   logic        rst_n, wr, rd, hit, req, we, ack, irq, trun, slow;
   logic [7:0]  addr, wdata, rdata, rx_first, rx_last, tx_first, tx_last, gap, mwdata, mrdata;
   logic [15:0] rx_base, tx_base;
   logic [23:0] maddr;
   logic [9:0]  tmo;
   int          fails = 0, n_checks = 0, n_irq = 0, n_wr = 0, run = 0, maxrun = 0;
   bit          busy = 0;

   always #20 clk = ~clk;

   ring_copy_dma #(.CNT_W(16)) u_dut (
      .clk_i(clk), .rst_n_i(rst_n), .sfr_wr_i(wr), .sfr_rd_i(rd),
      .sfr_addr_i(addr), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
      .rx_packet_ring_i(rx_base), .rx_ring_first_page_i(rx_first),
      .rx_ring_last_page_i(rx_last), .tx_packet_ring_i(tx_base),
      .tx_ring_first_page_i(tx_first), .tx_ring_last_page_i(tx_last),
      .chunk_gap_setting_i(gap), .timer_hit_i(hit), .mem_req_o(req), .mem_we_o(we),
      .mem_addr_o(maddr), .mem_wdata_o(mwdata), .mem_rdata_i(mrdata), .mem_ack_i(ack),
      .irq_o(irq), .timer_timeout_o(tmo), .timer_run_o(trun));

   mem_model u_mem (
      .clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .req_i(req), .we_i(we),
      .addr_i(maddr), .wdata_i(mwdata), .rdata_o(mrdata), .ack_o(ack));

   // idle runs between accesses, write count, interrupt pulses
   always @(posedge clk) begin
      if (irq) n_irq++;
      if (ack && we) n_wr++;
      if (!req) run++;
      else begin
         if (busy && n_wr > 0 && run > maxrun) maxrun = run;
         run = 0;
      end
   end

   function automatic logic [7:0] pat(input logic [23:0] a);
      return a[7:0] ^ 8'h5A;
   endfunction

   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask

   task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      @(negedge clk);
      d = rdata;
   endtask

   task automatic reg_wr(input logic [7:0] idx, input logic [23:0] v, input int n);
      for (int i = 0; i < n; i++) sfr_wr(8'h9C, v[8*i+:8]);
      sfr_wr(8'h9B, idx);
   endtask

   task automatic reg_rd(input logic [7:0] idx, input int n, output logic [23:0] v);
      logic [7:0] b;
      sfr_wr(8'h9B, idx);
      v = 24'h000000;
      for (int i = 0; i < n; i++) begin
         sfr_rd(8'h9C, b);
         v[8*i+:8] = b;
      end
   endtask

   task automatic check_reg(input logic [7:0] idx, input int n, input logic [23:0] e);
      logic [23:0] v;
      reg_rd(idx, n, v);
      `CHK(v, e)
   endtask

   task automatic launch(input logic [23:0] s, t, input logic [15:0] n, input logic [7:0] c);
      reg_wr(8'h02, s, 3);
      reg_wr(8'h06, t, 3);
      reg_wr(8'h0A, {8'h00, n}, 2);
      reg_wr(8'h00, {16'h0000, c}, 1);
   endtask

   task automatic wait_done(input int lim);
      logic [7:0] s;
      s = 8'h00;
      for (int i = 0; i < lim && s[0] !== 1'b1; i++) sfr_rd(8'h94, s);
      `CHK(s[0], 1'b1)
      if (s[0] !== 1'b1) finish_test();
   endtask

   task automatic t_regs();
      logic [7:0] s;
      check_reg(8'h00, 1, 24'h000000);
      check_reg(8'h0C, 2, 24'h000001);
      `CHK(tmo, 10'h001)
      `CHK(trun, 1'b0)
      sfr_rd(8'h94, s);
      `CHK(s, 8'h00)
      reg_wr(8'h02, 24'h123456, 3);
      check_reg(8'h02, 3, 24'h123456);
      reg_wr(8'h06, 24'hABCDEF, 3);
      check_reg(8'h06, 3, 24'hABCDEF);
      reg_wr(8'h0A, 24'h000102, 2);
      check_reg(8'h0A, 2, 24'h000102);
   endtask

   task automatic t_linear();
      n_irq = 0;
      launch(24'h000100, 24'h000400, 16'h0003, 8'h81);
      wait_done(50);
      for (int i = 0; i < 3; i++) `CHK(u_mem.mem[24'h400 + i], pat(24'h100 + i))
      `CHK(n_irq, 1)
      check_reg(8'h00, 1, 24'h000080);
   endtask

   task automatic t_chunk();
      gap = 8'h0A;
      n_wr = 0;
      maxrun = 0;
      n_irq = 0;
      busy = 1;
      launch(24'h000800, 24'h000C00, 16'd130, 8'h01);
      wait_done(400);
      busy = 0;
      `CHK(n_wr, 130)
      `CHK(u_mem.mem[24'hC81], pat(24'h881))
      `CHK(maxrun >= 11 && maxrun < 14, 1'b1)
      `CHK(n_irq, 0)
   endtask

   task automatic t_ring();
      logic [23:0] sa[4] = '{24'h0012FE, 24'h0012FF, 24'h001100, 24'h001101};
      logic [23:0] ta[4] = '{24'h0024FE, 24'h0024FF, 24'h002300, 24'h002301};
      slow = 1'b1;
      launch(sa[0], ta[0], 16'h0004, 8'h31);
      reg_wr(8'h00, 24'h000000, 1);
      check_reg(8'h00, 1, 24'h000031);
      wait_done(100);
      for (int i = 0; i < 4; i++) `CHK(u_mem.mem[ta[i]], pat(sa[i]))
      check_reg(8'h00, 1, 24'h000000);
      slow = 1'b0;
   endtask

   task automatic t_error();
      logic [23:0] s[4] = '{24'h000600, 24'h000700, 24'h000500, 24'h000100};
      logic [23:0] t[4] = '{24'h000900, 24'h000700, 24'h000502, 24'h000A00};
      logic [15:0] n[4] = '{16'h0000, 16'h0004, 16'h0004, 16'h0004};
      logic [7:0]  c[4] = '{8'h01, 8'h01, 8'h01, 8'h11};
      logic [7:0]  st;
      for (int i = 0; i < 4; i++) begin
         n_wr = 0;
         launch(s[i], t[i], n[i], c[i]);
         check_reg(8'h00, 1, {16'h0000, c[i] | 8'h04});
         reg_wr(8'h00, 24'h000002, 1);
         check_reg(8'h00, 1, 24'h000000);
         sfr_rd(8'h94, st);
         `CHK(st[0], 1'b0)
         `CHK(n_wr, 0)
      end
   endtask

   task automatic t_abort();
      logic [23:0] v;
      slow = 1'b1;
      n_wr = 0;
      launch(24'h003000, 24'h004000, 16'd100, 8'h01);
      sfr_wr(8'h9B, 8'hFF);
      v = 24'h000001;
      for (int i = 0; i < 50 && v[0] !== 1'b0; i++) reg_rd(8'h00, 1, v);
      `CHK(v, 24'h000000)
      `CHK(n_wr < 100, 1'b1)
      slow = 1'b0;
   endtask

   task automatic t_timer();
      logic [7:0] s;
      @(negedge clk);
      hit = 1'b1;
      @(negedge clk);
      hit = 1'b0;
      sfr_rd(8'h94, s);
      `CHK(s, 8'h02)
      reg_wr(8'h0C, 24'h001005, 2);
      `CHK(tmo, 10'h005)
      `CHK(trun, 1'b1)
      check_reg(8'h0C, 2, 24'h001005);
   endtask

   initial begin
      rst_n = 1'b0;
      {wr, rd, hit, slow} = 4'h0;
      {addr, wdata} = 16'h0000;
      {rx_base, rx_first, rx_last} = {16'h0010, 8'h01, 8'h02};
      {tx_base, tx_first, tx_last} = {16'h0020, 8'h03, 8'h04};
      gap = 8'h02;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      t_regs();
      t_linear();
      t_chunk();
      t_ring();
      t_error();
      t_abort();
      t_timer();
      finish_test();
   end
endmodule
